// file: bench/pdrs_host_model.sv
// Host adapter model: drives selects, address, strobes and write data.
// Assumes it shares core_clk with the device and that device outputs are registered.
`timescale 1ns/100ps
module pdrs_host_model (
   input  wire logic        core_clk,
   input  wire logic        data_oe,
   input  wire logic [15:0] data_out,
   output logic             cmd_sel_n,
   output logic             ctl_sel_n,
   output logic [2:0]       addr,
   output logic             rd_n,
   output logic             wr_n,
   output logic             host_oe,
   output logic [15:0]      host_data
);
   // ==========
   // Idle state
   // ==========
   // Idle means both blocks deselected, strobes high and the address parked at seven.
   initial begin
      cmd_sel_n = 1'b1;
      ctl_sel_n = 1'b1;
      addr      = 3'h7;
      rd_n      = 1'b1;
      wr_n      = 1'b1;
      host_oe   = 1'b0;
      host_data = 16'h0000;
   end

   // One strobed access. Address and data settle two cycles before the strobe and hold
   // well past its rise, since the device only sees pins through two flops.
   task automatic xfer(
      input  logic        wr,
      input  logic        c0,
      input  logic        c1,
      input  logic [2:0]  a,
      input  logic [15:0] wd,
      output logic        oe_mid,
      output logic [15:0] dq,
      output logic        oe_end
   );
      @(posedge core_clk);
      #1;
      cmd_sel_n = c0;
      ctl_sel_n = c1;
      addr      = a;
      host_oe   = wr;
      host_data = wd;
      repeat (2) @(posedge core_clk);
      #1;
      rd_n = wr;
      wr_n = !wr;
      repeat (6) @(posedge core_clk);
      #1;
      oe_mid = data_oe;
      dq     = data_out;
      rd_n   = 1'b1;
      wr_n   = 1'b1;
      repeat (4) @(posedge core_clk);
      #1;
      oe_end    = data_oe;
      cmd_sel_n = 1'b1;
      ctl_sel_n = 1'b1;
      addr      = 3'h7;
      host_oe   = 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
   endtask : xfer
endmodule : pdrs_host_model

// file: bench/tb_top.sv
// Self-checking bench for the register port: sweeps every select and address in both maps.
// Assumes the host model file is compiled first; the data wire is resolved here.
`timescale 1ns/100ps
module tb_top;
   import pdrs_pkg::*;
   logic        core_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        ce = 1'b1;
   logic        packet_mode = 1'b0;
   logic [7:0]  primary_status = 8'h00, failure_code = 8'h00, packet_phase_reason = 8'h00;
   logic [15:0] xfer_read_word = 16'h0000, last_bus = 16'h0000;
   logic        cmd_sel_n, ctl_sel_n, rd_n, wr_n, host_oe, data_oe, xfer_read_taken;
   logic        xfer_write_valid, command_valid, r_oe, r_end, exp_cv, exp_xw;
   logic [2:0]  addr;
   logic [15:0] host_data, data_out, xfer_write_word, r_dq, seen_xw, m_xw;
   logic [7:0]  command_parameter, sector_count, block_address_low, block_address_mid;
   logic [7:0]  block_address_high, drive_select, command_code, interface_control;
   logic [7:0]  m_parm, m_cnt, m_low, m_mid, m_high, m_drv, m_code, m_ctl;
   logic [3:0]  cnt_cv, cnt_xw, cnt_xr;
   int          n_errors = 0;
   int          tests_run = 0;
   // A released wire shows the inverse of its last level so stale data never passes.
   wire  [15:0] bus = data_oe ? data_out : (host_oe ? host_data : ~last_bus);

   always #2.5 core_clk = ~core_clk;

   // Pulse counters and the word seen with the write pulse.
   always @(posedge core_clk) begin
      last_bus <= bus;
      if (command_valid === 1'b1) cnt_cv <= cnt_cv + 4'h1;
      if (xfer_read_taken === 1'b1) cnt_xr <= cnt_xr + 4'h1;
      if (xfer_write_valid === 1'b1) begin
         cnt_xw  <= cnt_xw + 4'h1;
         seen_xw <= xfer_write_word;
      end
   end

   pdrs_host_model host (.core_clk(core_clk), .data_oe(data_oe), .data_out(data_out),
      .cmd_sel_n(cmd_sel_n), .ctl_sel_n(ctl_sel_n), .addr(addr), .rd_n(rd_n), .wr_n(wr_n),
      .host_oe(host_oe), .host_data(host_data));

   pdrs_port DUT (.core_clk(core_clk), .rst_n(rst_n), .ce(ce),
      .command_block_select_n(cmd_sel_n), .control_block_select_n(ctl_sel_n),
      .register_address(addr), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
      .data_in(bus), .data_out(data_out), .data_oe(data_oe), .packet_mode(packet_mode),
      .primary_status(primary_status), .failure_code(failure_code),
      .packet_phase_reason(packet_phase_reason), .xfer_read_word(xfer_read_word),
      .xfer_read_taken(xfer_read_taken), .xfer_write_word(xfer_write_word),
      .xfer_write_valid(xfer_write_valid), .command_parameter(command_parameter),
      .sector_count(sector_count), .block_address_low(block_address_low),
      .block_address_mid(block_address_mid), .block_address_high(block_address_high),
      .drive_select(drive_select), .command_code(command_code),
      .command_valid(command_valid), .interface_control(interface_control));

   // ==========
   // Checking
   // ==========
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic report_and_stop();
      if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop

   // Expected read answer as {drive, word}; select inputs are active low.
   function automatic logic [16:0] exp_read(input logic c0, input logic c1,
                                            input logic [2:0] a, input logic pk);
      if (c0 == c1) return 17'h0_0000;
      if (c0) return (a == ADDR_DRIVE) ? {9'h100, primary_status} : 17'h0_0000;
      case (a)
         ADDR_DATA:      return {1'b1, xfer_read_word};
         ADDR_FAIL_PARM: return {9'h100, failure_code};
         ADDR_COUNT:     return {9'h100, pk ? packet_phase_reason : m_cnt};
         ADDR_BA_LOW:    return pk ? 17'h0_0000 : {9'h100, m_low};
         ADDR_BA_MID:    return {9'h100, m_mid};
         ADDR_BA_HIGH:   return {9'h100, m_high};
         ADDR_DRIVE:     return {9'h100, m_drv};
         default:        return {9'h100, primary_status};
      endcase
   endfunction : exp_read

   // Reference update of the stored registers for one write.
   task automatic model_wr(input logic c0, input logic c1, input logic [2:0] a,
                           input logic [15:0] d);
      exp_cv = 1'b0;
      exp_xw = 1'b0;
      if (c0 == c1) return;
      if (c0) begin
         if (a == ADDR_DRIVE) m_ctl = d[7:0];
         return;
      end
      case (a)
         ADDR_DATA: begin
            m_xw   = d;
            exp_xw = 1'b1;
         end
         ADDR_FAIL_PARM: m_parm = d[7:0];
         ADDR_COUNT:     m_cnt = d[7:0];
         ADDR_BA_LOW:    if (!packet_mode) m_low = d[7:0];
         ADDR_BA_MID:    m_mid = d[7:0];
         ADDR_BA_HIGH:   m_high = d[7:0];
         ADDR_DRIVE:     m_drv = d[7:0];
         default: begin
            m_code = d[7:0];
            exp_cv = 1'b1;
         end
      endcase
   endtask : model_wr

   // One access with fresh core inputs, then every comparison that applies.
   task automatic do_access(input logic wr, input logic c0, input logic c1,
                            input logic [2:0] a, input logic [15:0] d);
      logic [16:0] exp;
      primary_status      = 8'($urandom);
      failure_code        = 8'($urandom);
      packet_phase_reason = 8'($urandom);
      xfer_read_word      = 16'($urandom);
      exp    = exp_read(c0, c1, a, packet_mode);
      cnt_cv = 4'h0;
      cnt_xw = 4'h0;
      cnt_xr = 4'h0;
      if (wr) model_wr(c0, c1, a, d);
      host.xfer(wr, c0, c1, a, d, r_oe, r_dq, r_end);
      check("released_after", r_end, 1'b0);
      if (wr) begin
         check("stored_a", {command_parameter, sector_count, block_address_low,
               block_address_mid}, {m_parm, m_cnt, m_low, m_mid});
         check("stored_b", {block_address_high, drive_select, command_code,
               interface_control}, {m_high, m_drv, m_code, m_ctl});
         check("write_pulses", {cnt_cv, cnt_xw}, {3'h0, exp_cv, 3'h0, exp_xw});
         if (exp_xw) check("data_word", seen_xw, m_xw);
      end else begin
         check("read_drive", r_oe, exp[16]);
         if (exp[16]) check("read_word", r_dq, exp[15:0]);
         check("read_taken", cnt_xr, !c0 && c1 && a == ADDR_DATA);
      end
   endtask : do_access

   // ==========
   // Sequence
   // ==========
   initial begin
      repeat (100000) @(posedge core_clk);
      n_errors++;
      report_and_stop();
   end

   initial begin
      {m_parm, m_cnt, m_low, m_mid, m_high, m_drv, m_code, m_ctl} = 64'h0;
      m_xw = 16'h0000;
      void'($urandom(78664));
      repeat (3) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      check("reset_stored", {command_parameter, sector_count, drive_select,
            interface_control}, 32'h0000_0000);
      // Every select and address combination, written then read, in both maps.
      for (int pk = 0; pk < 2; pk++) begin
         packet_mode = pk[0];
         for (int i = 0; i < 32; i++) do_access(1'b1, i[4], i[3], i[2:0], 16'($urandom));
         for (int i = 0; i < 32; i++) do_access(1'b0, i[4], i[3], i[2:0], 16'h0000);
         do_access(1'b0, 1'b1, 1'b0, ADDR_STAT_CMD, 16'h0000);
         check("obsolete_drive", r_oe, 1'b0);
         do_access(1'b0, 1'b1, 1'b0, ADDR_DRIVE, 16'h0000);
         check("shadow", {r_oe, r_dq}, {9'h100, primary_status});
         do_access(1'b0, 1'b0, 1'b1, ADDR_COUNT, 16'h0000);
         check("count_map", r_dq[7:0], pk[0] ? packet_phase_reason : m_cnt);
      end
      // Packet map: address three is dead, byte count low lands in shared storage.
      do_access(1'b1, 1'b0, 1'b1, ADDR_BA_LOW, 16'h00a5);
      check("unassigned", block_address_low, m_low);
      do_access(1'b1, 1'b0, 1'b1, ADDR_BA_MID, 16'h005a);
      packet_mode = 1'b0;
      do_access(1'b0, 1'b0, 1'b1, ADDR_BA_MID, 16'h0000);
      check("count_low", r_dq, 16'h005a);
      // With the clock enable low the strobe is never seen, so nothing may change.
      ce = 1'b0;
      host.xfer(1'b1, 1'b0, 1'b1, ADDR_COUNT, 16'h00c3, r_oe, r_dq, r_end);
      ce = 1'b1;
      check("frozen", sector_count, m_cnt);
      repeat (150) begin
         packet_mode = 1'($urandom);
         do_access(1'($urandom), 1'($urandom), 1'($urandom), 3'($urandom), 16'($urandom));
      end
      // A second reset in mid-run clears every stored register.
      rst_n = 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      check("rereset", {block_address_high, command_code, block_address_mid,
            block_address_low}, 32'h0000_0000);
      report_and_stop();
   end
endmodule : tb_top

// file: hw/pdrs_decode.sv
// Combinational decoder from selects, address and map choice to register target.
// Assumes its inputs are already synchronised to the core clock.
`timescale 1ns/100ps
module pdrs_decode
   import pdrs_pkg::*;
(
   input  wire logic       cmd_sel_n,
   input  wire logic       ctl_sel_n,
   input  wire logic [2:0] addr,
   input  wire logic       packet_mode,
   output pdrs_rd_e        rd_id,
   output pdrs_wr_e        wr_id
);

   // ==========================================================================
   // Address decode.
   // ==========================================================================
   // Both selects negated or both asserted leave everything unselected.
   always_comb begin
      rd_id = RD_NONE;
      wr_id = WR_NONE;
      if (!cmd_sel_n && ctl_sel_n) begin
         // Command block; the packet map differs only at two addresses.
         unique case (addr)
            ADDR_DATA: begin
               rd_id = RD_DATA;
               wr_id = WR_DATA;
            end
            ADDR_FAIL_PARM: begin
               rd_id = RD_FAIL;
               wr_id = WR_PARAM;
            end
            ADDR_COUNT: begin
               rd_id = packet_mode ? RD_REASON : RD_COUNT;
               wr_id = WR_COUNT;
            end
            ADDR_BA_LOW: begin
               // The packet map leaves this address unassigned.
               rd_id = packet_mode ? RD_NONE : RD_LOW;
               wr_id = packet_mode ? WR_NONE : WR_LOW;
            end
            ADDR_BA_MID: begin
               rd_id = RD_MID;
               wr_id = WR_MID;
            end
            ADDR_BA_HIGH: begin
               rd_id = RD_HIGH;
               wr_id = WR_HIGH;
            end
            ADDR_DRIVE: begin
               rd_id = RD_DRIVE;
               wr_id = WR_DRIVE;
            end
            ADDR_STAT_CMD: begin
               rd_id = RD_STATUS;
               wr_id = WR_COMMAND;
            end
         endcase
      end else if (cmd_sel_n && !ctl_sel_n && addr == ADDR_DRIVE) begin
         // Only one control block address answers; the obsolete one stays silent.
         rd_id = RD_SHADOW;
         wr_id = WR_CONTROL;
      end
   end

endmodule : pdrs_decode

// file: hw/pdrs_pkg.sv
// Shared constants and types for the parallel disk register select block.
// Assumes a single core clock domain; host pins are synchronised by the user of these names.
package pdrs_pkg;

   // ==========================================================================
   // Pin bundle layout after synchronisation.
   // ==========================================================================
   localparam int PIN_W       = 7;  // Width of the synchronised control pin vector.
   localparam int PIN_CMD     = 6;  // Command block select, active low.
   localparam int PIN_CTL     = 5;  // Control block select, active low.
   localparam int PIN_ADDR_HI = 4;  // Top bit of the register address.
   localparam int PIN_ADDR_LO = 2;  // Bottom bit of the register address.
   localparam int PIN_RD      = 1;  // Read strobe, active low.
   localparam int PIN_WR      = 0;  // Write strobe, active low.

   // ==========================================================================
   // Register addresses within each block.
   // ==========================================================================
   localparam logic [2:0] ADDR_DATA      = 3'h0;  // Transfer data port.
   localparam logic [2:0] ADDR_FAIL_PARM = 3'h1;  // Failure code / command parameter.
   localparam logic [2:0] ADDR_COUNT     = 3'h2;  // Sector count / packet phase reason.
   localparam logic [2:0] ADDR_BA_LOW    = 3'h3;  // Block address low / unassigned.
   localparam logic [2:0] ADDR_BA_MID    = 3'h4;  // Block address mid / length low.
   localparam logic [2:0] ADDR_BA_HIGH   = 3'h5;  // Block address high / length high.
   localparam logic [2:0] ADDR_DRIVE     = 3'h6;  // Drive select; shadow status in control.
   localparam logic [2:0] ADDR_STAT_CMD  = 3'h7;  // Status / command; obsolete in control.

   // ==========================================================================
   // Widths and reset values.
   // ==========================================================================
   localparam int          BYTE_W     = 8;         // Width of the byte registers.
   localparam int          WORD_W     = 16;        // Width of the data bus.
   localparam logic [7:0]  RESET_BYTE = 8'h00;     // Reset value of stored bytes.
   localparam logic [15:0] RESET_WORD = 16'h0000;  // Reset value of the bus word.

   // ==========================================================================
   // Decoded register targets.
   // ==========================================================================
   typedef enum logic [3:0] {
      RD_NONE   = 4'h0,
      RD_DATA   = 4'h1,
      RD_FAIL   = 4'h2,
      RD_COUNT  = 4'h3,
      RD_REASON = 4'h4,
      RD_LOW    = 4'h5,
      RD_MID    = 4'h6,
      RD_HIGH   = 4'h7,
      RD_DRIVE  = 4'h8,
      RD_STATUS = 4'h9,
      RD_SHADOW = 4'ha
   } pdrs_rd_e;

   typedef enum logic [3:0] {
      WR_NONE    = 4'h0,
      WR_DATA    = 4'h1,
      WR_PARAM   = 4'h2,
      WR_COUNT   = 4'h3,
      WR_LOW     = 4'h4,
      WR_MID     = 4'h5,
      WR_HIGH    = 4'h6,
      WR_DRIVE   = 4'h7,
      WR_COMMAND = 4'h8,
      WR_CONTROL = 4'h9
   } pdrs_wr_e;

endpackage : pdrs_pkg

// file: hw/pdrs_port.sv
// Device side of the parallel host register port: pin sync, decode, register file.
// Assumes host pins are asynchronous to core_clk and that the data bus wire is
// resolved outside from data_out and data_oe.
`timescale 1ns/100ps
module pdrs_port
   import pdrs_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   input  wire logic              ce,
   input  wire logic              command_block_select_n,
   input  wire logic              control_block_select_n,
   input  wire logic [2:0]        register_address,
   input  wire logic              read_strobe_n,
   input  wire logic              write_strobe_n,
   input  wire logic [WORD_W-1:0] data_in,
   output logic      [WORD_W-1:0] data_out,
   output logic                   data_oe,
   input  wire logic              packet_mode,
   input  wire logic [BYTE_W-1:0] primary_status,
   input  wire logic [BYTE_W-1:0] failure_code,
   input  wire logic [BYTE_W-1:0] packet_phase_reason,
   input  wire logic [WORD_W-1:0] xfer_read_word,
   output logic                   xfer_read_taken,
   output logic      [WORD_W-1:0] xfer_write_word,
   output logic                   xfer_write_valid,
   output logic      [BYTE_W-1:0] command_parameter,
   output logic      [BYTE_W-1:0] sector_count,
   output logic      [BYTE_W-1:0] block_address_low,
   output logic      [BYTE_W-1:0] block_address_mid,
   output logic      [BYTE_W-1:0] block_address_high,
   output logic      [BYTE_W-1:0] drive_select,
   output logic      [BYTE_W-1:0] command_code,
   output logic                   command_valid,
   output logic      [BYTE_W-1:0] interface_control
);

   // ==========================================================================
   // State.
   // ==========================================================================
   // The byte count and packet drive select share storage with block address
   // mid/high and the drive register, as the two maps name one set of latches.
   typedef struct packed {
      logic [PIN_W-1:0]  pin_m;      // First sync stage of control pins.
      logic [PIN_W-1:0]  pin_s;      // Second sync stage of control pins.
      logic [WORD_W-1:0] bus_m;      // First sync stage of the data bus.
      logic [WORD_W-1:0] bus_s;      // Second sync stage of the data bus.
      logic              rd_prev;    // Read strobe seen last cycle.
      logic              wr_prev;    // Write strobe seen last cycle.
      logic [WORD_W-1:0] dout;       // Bus read word.
      logic              oe;         // Bus drive enable.
      logic              rd_taken;   // Data word consumed pulse.
      logic [WORD_W-1:0] wword;      // Last written data word.
      logic              wvalid;     // Data word written pulse.
      logic [BYTE_W-1:0] param;      // Command parameter.
      logic [BYTE_W-1:0] count;      // Sector count.
      logic [BYTE_W-1:0] low;        // Block address low.
      logic [BYTE_W-1:0] mid;        // Block address mid / length low.
      logic [BYTE_W-1:0] high;       // Block address high / length high.
      logic [BYTE_W-1:0] drive;      // Drive select.
      logic [BYTE_W-1:0] cmd;        // Command code.
      logic              cvalid;     // Command written pulse.
      logic [BYTE_W-1:0] ctrl;       // Interface control.
   } pdrs_state_s;

   pdrs_state_s st_q;  // Registered state.
   pdrs_state_s st_d;  // Next state.
   pdrs_rd_e    rd_id; // Decoded read target.
   pdrs_wr_e    wr_id; // Decoded write target.
   logic        rd_on; // Read strobe asserted (synchronised).
   logic        wr_on; // Write strobe asserted (synchronised).
   logic [WORD_W-1:0] rd_word; // Word the decoded register would return.

   assign rd_on = !st_q.pin_s[PIN_RD];
   assign wr_on = !st_q.pin_s[PIN_WR];

   // ==========================================================================
   // Decoder.
   // ==========================================================================
   pdrs_decode u_decode (
      .cmd_sel_n   (st_q.pin_s[PIN_CMD]),
      .ctl_sel_n   (st_q.pin_s[PIN_CTL]),
      .addr        (st_q.pin_s[PIN_ADDR_HI:PIN_ADDR_LO]),
      .packet_mode (packet_mode),
      .rd_id       (rd_id),
      .wr_id       (wr_id)
   );

   // ==========================================================================
   // Read mux.
   // ==========================================================================
   // Byte registers sit in the low lane; the upper lane reads zero.
   always_comb begin
      rd_word = RESET_WORD;
      unique case (rd_id)
         RD_NONE:   rd_word = RESET_WORD;
         RD_DATA:   rd_word = xfer_read_word;
         RD_FAIL:   rd_word = {RESET_BYTE, failure_code};
         RD_COUNT:  rd_word = {RESET_BYTE, st_q.count};
         RD_REASON: rd_word = {RESET_BYTE, packet_phase_reason};
         RD_LOW:    rd_word = {RESET_BYTE, st_q.low};
         RD_MID:    rd_word = {RESET_BYTE, st_q.mid};
         RD_HIGH:   rd_word = {RESET_BYTE, st_q.high};
         RD_DRIVE:  rd_word = {RESET_BYTE, st_q.drive};
         RD_STATUS: rd_word = {RESET_BYTE, primary_status};
         RD_SHADOW: rd_word = {RESET_BYTE, primary_status};
         default:   rd_word = RESET_WORD;
      endcase
   end

   // ==========================================================================
   // Next state.
   // ==========================================================================
   // Writes land on the strobe's negating edge, where the host guarantees the
   // data is settled; this costs a sync delay but avoids sampling mid-setup.
   always_comb begin
      st_d          = st_q;
      st_d.pin_m    = {command_block_select_n, control_block_select_n,
                       register_address, read_strobe_n, write_strobe_n};
      st_d.pin_s    = st_q.pin_m;
      st_d.bus_m    = data_in;
      st_d.bus_s    = st_q.bus_m;
      st_d.rd_prev  = rd_on;
      st_d.wr_prev  = wr_on;
      st_d.rd_taken = 1'b0;
      st_d.wvalid   = 1'b0;
      st_d.cvalid   = 1'b0;
      // Drive the bus only for a readable target while the strobe is held.
      st_d.oe   = rd_on && (rd_id != RD_NONE);
      st_d.dout = rd_word;
      if (st_q.rd_prev && !rd_on && rd_id == RD_DATA) begin
         st_d.rd_taken = 1'b1;
      end
      if (st_q.wr_prev && !wr_on) begin
         // Only the addressed register changes; unselected writes fall through.
         unique case (wr_id)
            WR_NONE: begin
               st_d.wvalid = 1'b0;
            end
            WR_DATA: begin
               st_d.wword  = st_q.bus_s;
               st_d.wvalid = 1'b1;
            end
            WR_PARAM:   st_d.param = st_q.bus_s[BYTE_W-1:0];
            WR_COUNT:   st_d.count = st_q.bus_s[BYTE_W-1:0];
            WR_LOW:     st_d.low   = st_q.bus_s[BYTE_W-1:0];
            WR_MID:     st_d.mid   = st_q.bus_s[BYTE_W-1:0];
            WR_HIGH:    st_d.high  = st_q.bus_s[BYTE_W-1:0];
            WR_DRIVE:   st_d.drive = st_q.bus_s[BYTE_W-1:0];
            WR_COMMAND: begin
               st_d.cmd    = st_q.bus_s[BYTE_W-1:0];
               st_d.cvalid = 1'b1;
            end
            WR_CONTROL: st_d.ctrl  = st_q.bus_s[BYTE_W-1:0];
            default:    st_d.wvalid = 1'b0;
         endcase
      end
   end

   // ==========================================================================
   // State register.
   // ==========================================================================
   // Strobes reset to idle (high) so no edge is seen right after reset.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st_q          <= '0;
         st_q.pin_m    <= {PIN_W{1'b1}};
         st_q.pin_s    <= {PIN_W{1'b1}};
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   assign data_out           = st_q.dout;
   assign data_oe            = st_q.oe;
   assign xfer_read_taken    = st_q.rd_taken;
   assign xfer_write_word    = st_q.wword;
   assign xfer_write_valid   = st_q.wvalid;
   assign command_parameter  = st_q.param;
   assign sector_count       = st_q.count;
   assign block_address_low  = st_q.low;
   assign block_address_mid  = st_q.mid;
   assign block_address_high = st_q.high;
   assign drive_select       = st_q.drive;
   assign command_code       = st_q.cmd;
   assign command_valid      = st_q.cvalid;
   assign interface_control  = st_q.ctrl;

   // ==========================================================================
   // Assertions.
   // ==========================================================================
   logic cmd_only; // Command block alone selected.
   logic ctl_only; // Control block alone selected.
   logic wr_edge;  // Write strobe negating this cycle.
   logic [2:0] a_s;
   assign cmd_only = !st_q.pin_s[PIN_CMD] && st_q.pin_s[PIN_CTL];
   assign ctl_only = st_q.pin_s[PIN_CMD] && !st_q.pin_s[PIN_CTL];
   assign wr_edge  = st_q.wr_prev && !wr_on;
   assign a_s      = st_q.pin_s[PIN_ADDR_HI:PIN_ADDR_LO];

   property p_status_read;
      @(posedge core_clk) disable iff (!rst_n)
      ce && rd_on && cmd_only && a_s == ADDR_STAT_CMD
      |=> data_oe && data_out == {RESET_BYTE, $past(primary_status)};
   endproperty
   a_status_read: assert property (p_status_read) else $error("status read wrong");

   property p_shadow_read;
      @(posedge core_clk) disable iff (!rst_n)
      ce && rd_on && ctl_only && a_s == ADDR_DRIVE
      |=> data_oe && data_out == {RESET_BYTE, $past(primary_status)};
   endproperty
   a_shadow_read: assert property (p_shadow_read) else $error("shadow read wrong");

   property p_both_selected;
      @(posedge core_clk) disable iff (!rst_n)
      ce && !st_q.pin_s[PIN_CMD] && !st_q.pin_s[PIN_CTL] |=> !data_oe;
   endproperty
   a_both_selected: assert property (p_both_selected) else $error("bus driven");

   property p_reason_read;
      @(posedge core_clk) disable iff (!rst_n)
      ce && packet_mode && rd_on && cmd_only && a_s == ADDR_COUNT
      |=> data_out == {RESET_BYTE, $past(packet_phase_reason)};
   endproperty
   a_reason_read: assert property (p_reason_read) else $error("reason read wrong");

   property p_unassigned_write;
      @(posedge core_clk) disable iff (!rst_n)
      ce && packet_mode && wr_edge && cmd_only && a_s == ADDR_BA_LOW
      |=> block_address_low == $past(block_address_low);
   endproperty
   a_unassigned_write: assert property (p_unassigned_write) else $error("low changed");

   property p_obsolete_silent;
      @(posedge core_clk) disable iff (!rst_n)
      ce && ctl_only && a_s == ADDR_STAT_CMD |=> !data_oe;
   endproperty
   a_obsolete_silent: assert property (p_obsolete_silent) else $error("obsolete drove");

   property p_oe_cause;
      @(posedge core_clk) disable iff (!rst_n)
      $rose(data_oe) |-> $past(rd_on) && $past(rd_id) != RD_NONE;
   endproperty
   a_oe_cause: assert property (p_oe_cause) else $error("oe without read");

   property p_command_write;
      @(posedge core_clk) disable iff (!rst_n)
      ce && wr_edge && cmd_only && a_s == ADDR_STAT_CMD
      |=> command_valid && command_code == $past(st_q.bus_s[BYTE_W-1:0]) ##1 !command_valid;
   endproperty
   a_command_write: assert property (p_command_write) else $error("command lost");

   c_status_read: cover property (@(posedge core_clk) disable iff (!rst_n)
      ce && rd_on && cmd_only && a_s == ADDR_STAT_CMD);
   c_packet_read: cover property (@(posedge core_clk) disable iff (!rst_n)
      ce && packet_mode && rd_on && cmd_only && a_s == ADDR_COUNT);
   c_command_write: cover property (@(posedge core_clk) disable iff (!rst_n) command_valid);

endmodule : pdrs_port
